// ---- core/deil_pkg.sv ----
// package: register map, field positions and reset values of the error interrupt block
package deil_pkg;

	localparam logic [7:0] DEIL_OFS_IRQ_CTRL = 8'h00_E0;
	localparam logic [7:0] DEIL_OFS_MASK     = 8'h00_E1;
	localparam logic [7:0] DEIL_OFS_STATUS   = 8'h00_E5;

	localparam int DEIL_BIT_IRQ_EN      = 0;
	localparam int DEIL_BIT_SYNC        = 7;
	localparam int DEIL_BIT_CRC         = 6;
	localparam int DEIL_BIT_UNC_ECC     = 5;
	localparam int DEIL_BIT_COR_ECC     = 4;
	localparam int DEIL_BIT_LLP         = 3;
	localparam int DEIL_BIT_LEADER      = 2;
	localparam int DEIL_BIT_PLL_UNLOCK  = 0;

	// implemented flag positions; bit 1 is reserved and reads zero
	localparam logic [7:0] DEIL_FLAG_BITS     = 8'h00_FD;
	localparam logic [7:0] DEIL_RST_IRQ_CTRL  = 8'h00_00;
	localparam logic [7:0] DEIL_RST_MASK      = 8'h00_00;
	localparam logic [7:0] DEIL_RST_STATUS    = 8'h00_01;

	typedef enum logic [1:0] {
		DEIL_LOCK_IDLE = 2'b01,
		DEIL_LOCK_HELD = 2'b10
	} deil_lock_t;

endpackage : deil_pkg

// ---- core/deil_evt_if.sv ----
// interface: event pulses from the lock watcher into the flag logic
`timescale 1ns/1ps
`default_nettype none
interface deil_evt_if;
	logic unlock_evt;
	logic locked;
	modport src (output unlock_evt, output locked);
	modport dst (input unlock_evt, input locked);
endinterface : deil_evt_if
`default_nettype wire

// ---- core/deil_lock_watch.sv ----
// module: synchronises the pll lock level and pulses on each lock loss
`timescale 1ns/1ps
`default_nettype none
module deil_lock_watch
	import deil_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pll_lock,
	deil_evt_if.src   evt
);
	logic       sync1_q;
	logic       sync2_q;
	deil_lock_t st_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= pll_lock;
			sync2_q <= sync1_q;
		end
	end

	// one pulse per locked to unlocked transition
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q           <= DEIL_LOCK_IDLE;
			evt.unlock_evt <= 1'b0;
		end else begin
			evt.unlock_evt <= 1'b0;
			case (st_q)
				DEIL_LOCK_IDLE: begin
					if (sync2_q) begin
						st_q <= DEIL_LOCK_HELD;
					end
				end
				DEIL_LOCK_HELD: begin
					if (!sync2_q) begin
						st_q           <= DEIL_LOCK_IDLE;
						evt.unlock_evt <= 1'b1;
					end
				end
				default: begin
					st_q <= DEIL_LOCK_IDLE;
				end
			endcase
		end
	end

	assign evt.locked = (st_q == DEIL_LOCK_HELD);

endmodule : deil_lock_watch
`default_nettype wire

// ---- core/deil_top.sv ----
// module: error flags, masks and interrupt pin of the video bridge receiver
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module deil_top
	import deil_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       sync_packet_error,
	input  wire logic       payload_checksum_error,
	input  wire logic       header_uncorrectable,
	input  wire logic       header_corrected,
	input  wire logic       low_level_protocol,
	input  wire logic       leader_sequence_bit,
	input  wire logic       pll_lock,
	output logic            irq_o,
	output logic            irq_oe,
	output logic            irq_level
);
	import deil_pkg::*;

	logic [7:0] ctrl_q;
	logic [7:0] mask_q;
	logic [7:0] status_q;
	logic [7:0] status_d;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic [5:0] err_s1_q;
	logic [5:0] err_s2_q;
	logic       irq_d;

	deil_evt_if evt ();

	deil_lock_watch u_lock (
		.mclk     (mclk),
		.rst      (rst),
		.pll_lock (pll_lock),
		.evt      (evt)
	);

	// error strobes come from the packet processor on its own clock
	always_ff @(posedge mclk) begin
		if (rst) begin
			err_s1_q <= 6'h00;
			err_s2_q <= 6'h00;
		end else begin
			err_s1_q <= {sync_packet_error, payload_checksum_error, header_uncorrectable,
				header_corrected, low_level_protocol, leader_sequence_bit};
			err_s2_q <= err_s1_q;
		end
	end

	// no gating by restart or video state, so restart-time errors still latch
	always_comb begin
		set_vec                     = 8'h00;
		set_vec[DEIL_BIT_SYNC]      = err_s2_q[5];
		set_vec[DEIL_BIT_CRC]       = err_s2_q[4];
		set_vec[DEIL_BIT_UNC_ECC]   = err_s2_q[3];
		set_vec[DEIL_BIT_COR_ECC]   = err_s2_q[2];
		set_vec[DEIL_BIT_LLP]       = err_s2_q[1];
		set_vec[DEIL_BIT_LEADER]    = err_s2_q[0];
		set_vec[DEIL_BIT_PLL_UNLOCK] = evt.unlock_evt;
	end

	always_comb begin
		clr_vec = 8'h00;
		if (reg_wr && reg_addr == DEIL_OFS_STATUS) begin
			clr_vec = reg_wdata;
		end
		status_d = ((status_q & ~clr_vec) | set_vec) & DEIL_FLAG_BITS;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			status_q <= DEIL_RST_STATUS;
		end else begin
			status_q <= status_d;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_q <= DEIL_RST_IRQ_CTRL;
			mask_q <= DEIL_RST_MASK;
		end else if (reg_wr) begin
			if (reg_addr == DEIL_OFS_IRQ_CTRL) begin
				ctrl_q <= reg_wdata & 8'h00_01;
			end else if (reg_addr == DEIL_OFS_MASK) begin
				mask_q <= reg_wdata & DEIL_FLAG_BITS;
			end
		end
	end

	// read data is one cycle after the strobe, zero otherwise and for holes
	always_ff @(posedge mclk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == DEIL_OFS_IRQ_CTRL) begin
				reg_rdata <= ctrl_q;
			end else if (reg_addr == DEIL_OFS_MASK) begin
				reg_rdata <= mask_q;
			end else if (reg_addr == DEIL_OFS_STATUS) begin
				reg_rdata <= status_q;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// evaluated from registered state so the pin lags a flag change by one cycle
	assign irq_d = |(status_q & mask_q);

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_o     <= 1'b0;
			irq_oe    <= 1'b0;
			irq_level <= 1'b0;
		end else begin
			irq_level <= irq_d;
			irq_o     <= irq_d & ctrl_q[DEIL_BIT_IRQ_EN];
			irq_oe    <= ctrl_q[DEIL_BIT_IRQ_EN];
		end
	end

	// assertions
	float_when_off_a: assert property (@(posedge mclk) disable iff (rst)
		!$past(ctrl_q[DEIL_BIT_IRQ_EN]) |-> !irq_oe && !irq_o)
		else $error("irq pin driven while output disabled");

	drive_on_flag_a: assert property (@(posedge mclk) disable iff (rst)
		(ctrl_q[0] && (|(status_q & mask_q))) |=> irq_o && irq_oe)
		else $error("irq not raised for enabled flag");

	mask_block_a: assert property (@(posedge mclk) disable iff (rst)
		((status_q & mask_q) == 8'h00) |=> !irq_o && !irq_level)
		else $error("masked flag raised irq");

	sync_set_a: assert property (@(posedge mclk) disable iff (rst)
		err_s2_q[5] |=> status_q[DEIL_BIT_SYNC])
		else $error("sync error not latched");

	crc_set_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(err_s1_q[4]) |=> ##1 status_q[DEIL_BIT_CRC])
		else $error("checksum error not latched");

	unc_set_a: assert property (@(posedge mclk) disable iff (rst)
		err_s2_q[3] |=> status_q[DEIL_BIT_UNC_ECC])
		else $error("uncorrectable error not latched");

	cor_set_a: assert property (@(posedge mclk) disable iff (rst)
		err_s2_q[2] |=> status_q[DEIL_BIT_COR_ECC])
		else $error("corrected error not latched");

	llp_set_a: assert property (@(posedge mclk) disable iff (rst)
		err_s2_q[1] |=> status_q[DEIL_BIT_LLP])
		else $error("protocol error not latched");

	leader_set_a: assert property (@(posedge mclk) disable iff (rst)
		err_s2_q[0] |=> status_q[DEIL_BIT_LEADER])
		else $error("leader error not latched");

	sequence lock_lost_s;
		evt.locked ##1 !evt.locked;
	endsequence

	unlock_set_a: assert property (@(posedge mclk) disable iff (rst)
		lock_lost_s |=> status_q[DEIL_BIT_PLL_UNLOCK])
		else $error("lock loss not latched");

	sticky_flag_a: assert property (@(posedge mclk) disable iff (rst)
		(status_q[7] && !(reg_wr && reg_addr == DEIL_OFS_STATUS && reg_wdata[7]))
		|=> status_q[7])
		else $error("flag cleared without write one");

	set_wins_a: assert property (@(posedge mclk) disable iff (rst)
		(set_vec[6] && reg_wr && reg_addr == DEIL_OFS_STATUS && reg_wdata[6])
		|=> status_q[6])
		else $error("clear beat same-cycle set");

	clear_drop_a: assert property (@(posedge mclk) disable iff (rst)
		(ctrl_q[0] && $fell(|(status_q & mask_q)) && $stable(ctrl_q[0]))
		|=> !irq_o)
		else $error("irq held after last flag cleared");

	sequence status_read_s;
		reg_rd && reg_addr == DEIL_OFS_STATUS;
	endsequence

	read_status_a: assert property (@(posedge mclk) disable iff (rst)
		status_read_s |=> reg_rdata == $past(status_q))
		else $error("status read data wrong");

	reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
		!status_q[1] && !mask_q[1])
		else $error("reserved bit set");

	zero_write_a: assert property (@(posedge mclk) disable iff (rst)
		(status_q[5] && reg_wr && reg_addr == DEIL_OFS_STATUS && !reg_wdata[5])
		|=> status_q[5])
		else $error("zero write cleared a flag");

	one_clears_a: assert property (@(posedge mclk) disable iff (rst)
		(reg_wr && reg_addr == DEIL_OFS_STATUS && reg_wdata[4] && !set_vec[4])
		|=> !status_q[4])
		else $error("write one did not clear flag");

	level_track_a: assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> irq_level == $past(|(status_q & mask_q)))
		else $error("irq level does not follow flags");

endmodule : deil_top
`default_nettype wire

// ---- test/deil_host_pin.sv ----
// host side of the interrupt pin: resolves the pin level the host sees
`timescale 1ns/1ps
`default_nettype none
module deil_host_pin (
	input  wire logic mclk,
	input  wire logic irq_o,
	input  wire logic irq_oe,
	output logic      pin
);
	logic alt_q;
	// no pull on the pin, so a floating pin toggles and never looks like a stable level
	initial begin
		alt_q = 1'b0;
		forever begin
			@(posedge mclk);
			alt_q <= ~alt_q;
		end
	end
	assign pin = irq_oe ? irq_o : alt_q;
endmodule : deil_host_pin
`default_nettype wire

// ---- test/dsi_error_interrupt_logic_tb.sv ----
// self-checking testbench of the error flag and interrupt block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, a, e); end end
module dsi_error_interrupt_logic_tb;
	import deil_pkg::*;
	logic       mclk, rst, reg_wr, reg_rd, pll_lock, irq_o, irq_oe, irq_level, pin;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [5:0] ev;
	int         fails, check_count;
	deil_top uut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.sync_packet_error(ev[5]), .payload_checksum_error(ev[4]),
		.header_uncorrectable(ev[3]), .header_corrected(ev[2]),
		.low_level_protocol(ev[1]), .leader_sequence_bit(ev[0]), .pll_lock(pll_lock),
		.irq_o(irq_o), .irq_oe(irq_oe), .irq_level(irq_level));
	deil_host_pin host (.mclk(mclk), .irq_o(irq_o), .irq_oe(irq_oe), .pin(pin));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge mclk); reg_wr <= 1'b0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge mclk); reg_rd <= 1'b0;
		@(posedge mclk); d = reg_rdata;
		`CHK(d, e)
	endtask : rd
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic reset_values();
		`CHK(irq_oe, 1'b0)
		rd(DEIL_OFS_IRQ_CTRL, 8'h00_00);
		rd(DEIL_OFS_MASK, 8'h00_00);
		rd(DEIL_OFS_STATUS, 8'h00_01);
		rd(8'h00_10, 8'h00_00);
		wr(DEIL_OFS_STATUS, 8'h00_00);
		rd(DEIL_OFS_STATUS, 8'h00_01);
		wr(DEIL_OFS_STATUS, 8'h00_01);
		rd(DEIL_OFS_STATUS, 8'h00_00);
	endtask : reset_values
	task automatic events_set();
		logic [7:0] exp_s;
		exp_s = 8'h00_00;
		for (int i = 5; i >= 0; i--) begin
			ev[i] <= 1'b1;
			@(posedge mclk); ev[i] <= 1'b0;
			repeat (6) @(posedge mclk);
			exp_s[i + 2] = 1'b1;
			rd(DEIL_OFS_STATUS, exp_s);
		end
	endtask : events_set
	task automatic pin_path();
		wr(DEIL_OFS_MASK, 8'h00_80);
		repeat (2) @(posedge mclk);
		`CHK(irq_oe, 1'b0)
		`CHK(irq_level, 1'b1)
		wr(DEIL_OFS_IRQ_CTRL, 8'h00_01);
		repeat (2) @(posedge mclk);
		`CHK({irq_oe, pin}, 2'b11)
		wr(DEIL_OFS_STATUS, 8'h00_80);
		repeat (2) @(posedge mclk);
		`CHK({irq_oe, pin}, 2'b10)
		rd(DEIL_OFS_STATUS, 8'h00_7C);
		wr(DEIL_OFS_STATUS, 8'h00_FF);
		rd(DEIL_OFS_STATUS, 8'h00_00);
	endtask : pin_path
	task automatic lock_loss();
		wr(DEIL_OFS_MASK, 8'h00_01);
		pll_lock <= 1'b1;
		repeat (8) @(posedge mclk);
		rd(DEIL_OFS_STATUS, 8'h00_00);
		`CHK(pin, 1'b0)
		pll_lock <= 1'b0;
		repeat (8) @(posedge mclk);
		`CHK(pin, 1'b1)
		rd(DEIL_OFS_STATUS, 8'h00_01);
		wr(DEIL_OFS_IRQ_CTRL, 8'h00_00);
		repeat (2) @(posedge mclk);
		`CHK(irq_oe, 1'b0)
	endtask : lock_loss
	initial begin
		rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00_00;
		reg_wdata = 8'h00_00; ev = 6'h00; pll_lock = 1'b0;
		fails = 0; check_count = 0;
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		reset_values();
		events_set();
		pin_path();
		lock_loss();
		wrap_up();
	end
	// watchdog so a stuck sequence still reaches the verdict
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		wrap_up();
	end
endmodule : dsi_error_interrupt_logic_tb
`default_nettype wire
